// *** core/aoc_pkg.sv ***
// Purpose: shared constants for the offset and low-power control block
// Assumes: 8-bit register port, 3-bit register index
// Notes: register offsets are byte indices on the plain port
package aoc_pkg;

  // register indices
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_CTRL2 = 3'h1;
  localparam logic [2:0] A_STAT = 3'h2;
  localparam logic [2:0] A_RES_H = 3'h3;
  localparam logic [2:0] A_RES_L = 3'h4;
  localparam logic [2:0] A_OFS_H = 3'h5;
  localparam logic [2:0] A_OFS_L = 3'h6;

  // control field positions
  localparam int C_EN = 0;
  localparam int C_MODE = 1;
  localparam int C_DIFF = 3;
  localparam int C_CONT = 4;
  localparam int C_HWT = 5;
  localparam int C_CLK = 6;

  // control 2 field positions
  localparam int C2_AVG = 0;
  localparam int C2_AVGS = 1;
  localparam int C2_CMP = 3;
  localparam int C2_IE = 4;
  localparam int C2_START = 5;
  localparam int C2_CAL = 6;

  // status field positions
  localparam int S_DONE = 0;
  localparam int S_BUSY = 1;
  localparam int S_CAL = 2;

  // clock source codes
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // resolution mode codes
  localparam logic [1:0] M_8 = 2'h0;
  localparam logic [1:0] M_12 = 2'h1;
  localparam logic [1:0] M_10 = 2'h2;
  localparam logic [1:0] M_16 = 2'h3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [15:0] OFS_RST = 16'h0000;
  localparam logic [15:0] RES_RST = 16'h0000;

  // averaging count is 1 << (select + base)
  localparam logic [2:0] AVG_BASE = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } aoc_state_t;

endpackage

// *** core/aoc_ctrl.sv ***
// Purpose: offset correction, saturation and low-power mode control
// Assumes: converter core signals on mclk, one clock domain
// Notes: compare evaluation and sampling live outside this block
//
// Behaviour
// - offset is one signed left-justified 16-bit word
// - subtract offset, then store into result pair
// - clamp out-of-range results to mode limits
// - lower limit 0x0000 single-ended, sign-extended -2^(n-1) differential (0x8000 at 16 bits)
// - 8-bit single-ended uses offset bits 14..7
// - 9-bit differential uses same bits, sign at 8
// - 16-bit differential subtracts offset bit for bit
// - 16-bit single-ended offset has no bit zero
// - calibration end loads offset; writes override later
// - averaging: subtract offset from averaged value
// - running conversion survives entry into wait
// - in wait only hardware or continuous starts
// - all clock sources usable during wait
// - each conversion sets done flag, interrupt wakes
// - averaging or compare gate the done flag
// - single mode compare fail returns idle quietly
// - stop3 without async clock aborts, keeps registers
// - stop3 with async clock keeps converting
// - stop3 result holds first completed conversion when compare and averaging are off
// - stop3 done flag and interrupt wake system
// - stop2 disables and resets every register
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module aoc_ctrl
  import aoc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic hw_trig,
  input wire logic wait_mode,
  input wire logic stop3_mode,
  input wire logic stop2_mode,
  input wire logic samp_valid,
  input wire logic [15:0] samp_data,
  input wire logic cmp_true,
  input wire logic cal_done,
  input wire logic [15:0] cal_offset,
  output logic conv_start,
  output logic conv_abort,
  output logic cal_start,
  output logic irq
);

  logic [7:0] ctrl_r;
  logic [7:0] ctrl2_r;
  logic [15:0] ofs_r;
  logic [15:0] res_r;
  logic done_r;
  logic cal_r;
  logic s3_hold_r;
  logic [4:0] cnt_r;
  logic signed [22:0] acc_r;
  aoc_state_t state_r;
  aoc_state_t state_nxt;

  logic en;
  logic [1:0] mode;
  logic diff;
  logic cont;
  logic hwt;
  logic [1:0] clk_sel;
  logic avg_en;
  logic [1:0] avgs;
  logic cmp_en;
  logic ie;

  // field views
  assign en = ctrl_r[C_EN];
  assign mode = ctrl_r[C_MODE+:2];
  assign diff = ctrl_r[C_DIFF];
  assign cont = ctrl_r[C_CONT];
  assign hwt = ctrl_r[C_HWT];
  assign clk_sel = ctrl_r[C_CLK+:2];
  assign avg_en = ctrl2_r[C2_AVG];
  assign avgs = ctrl2_r[C2_AVGS+:2];
  assign cmp_en = ctrl2_r[C2_CMP];
  assign ie = ctrl2_r[C2_IE];

  logic wr_ok;
  logic stop_kill;
  logic kill;
  logic sw_go;
  logic hw_go;
  logic go;

  // registers are locked while calibration runs
  assign wr_ok = wr && !cal_r;
  // stop3 only stops the converter if its clock dies with the bus
  assign stop_kill = stop3_mode && (clk_sel != CLK_ASYNC);
  // wait never kills a conversion, whatever the clock source
  assign kill = stop_kill || stop2_mode || !en;
  // the core is asleep in wait or stop, so software starts are refused
  assign sw_go = wr_ok && (addr == A_CTRL2) && wdata[C2_START] && !hwt
                 && !wait_mode && !stop3_mode;
  assign hw_go = hw_trig && hwt;
  assign go = (state_r == ST_IDLE) && en && (sw_go || hw_go) && !kill;

  // resolution in bits for the active mode and conversion type
  logic [4:0] nbits;
  always_comb begin
    unique case (mode)
      M_8: nbits = diff ? 5'd9 : 5'd8;
      M_12: nbits = diff ? 5'd13 : 5'd12;
      M_10: nbits = diff ? 5'd11 : 5'd10;
      M_16: nbits = 5'd16;
    endcase
  end

  // offset aligned to the result lsb, sign carried from bit 15
  logic signed [17:0] ofs18;
  logic signed [17:0] off_al;
  logic [4:0] ofs_sh;
  assign ofs18 = {{2{ofs_r[15]}}, ofs_r};
  // shift of 16-n (single-ended) or 17-n (differential) from ofs*2
  assign ofs_sh = diff ? 5'(5'd17 - nbits) : 5'(5'd16 - nbits);
  // doubling first leaves no offset bit under result bit 0 in 16b se
  assign off_al = (ofs18 <<< 1) >>> ofs_sh;

  // raw sample: differential data arrive sign-extended
  logic signed [17:0] raw18;
  assign raw18 = diff ? {{2{samp_data[15]}}, samp_data} : {2'b00, samp_data};

  // averaging accumulator and group end
  logic signed [22:0] acc_nxt;
  logic [2:0] avg_sh;
  logic [4:0] cnt_last;
  logic last;
  logic signed [17:0] val18;
  assign acc_nxt = acc_r + 23'(raw18);
  assign avg_sh = 3'(avgs) + AVG_BASE;
  assign cnt_last = 5'((6'd1 << avg_sh) - 6'd1);
  assign last = !avg_en || (cnt_r == cnt_last);
  // offset is applied once, to the averaged value
  assign val18 = avg_en ? 18'(acc_nxt >>> avg_sh) : raw18;

  // correction and saturation
  logic signed [17:0] corr;
  logic signed [17:0] lim_hi;
  logic signed [17:0] lim_lo;
  logic [15:0] sat_val;
  assign corr = val18 - off_al;
  always_comb begin
    if (diff) begin
      lim_hi = (18'sd1 <<< 5'(nbits - 5'd1)) - 18'sd1;
      lim_lo = -(18'sd1 <<< 5'(nbits - 5'd1));
    end else begin
      lim_hi = (18'sd1 <<< nbits) - 18'sd1;
      lim_lo = 18'sd0;
    end
    if (corr > lim_hi) begin
      sat_val = lim_hi[15:0];
    end else if (corr < lim_lo) begin
      sat_val = lim_lo[15:0];
    end else begin
      sat_val = corr[15:0];
    end
  end

  // completion qualification
  logic fin;
  logic pass;
  logic xfer;
  logic plain;
  assign fin = (state_r == ST_CONV) && samp_valid && !kill && last;
  assign pass = !cmp_en || cmp_true;
  assign plain = !cmp_en && !avg_en;
  // in stop3 the first plain result is kept until exit
  assign xfer = fin && pass && !s3_hold_r;

  logic restart;
  logic more;
  // a non-final sample of an averaging group asks for the next one
  assign more = (state_r == ST_CONV) && samp_valid && !kill && !last;
  // a failed compare in single mode drops to idle with no flag
  assign restart = fin && cont;

  // conversion sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        // a kill outranks completion, so no result lands on an abort edge
        if (kill) begin
          state_nxt = ST_IDLE;
        end else if (fin && !cont) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // start and abort strobes to the converter core
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= go || more || restart;
      conv_abort <= (state_r == ST_CONV) && kill;
    end
  end

  // averaging count and accumulator, cleared per group
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
      acc_r <= 23'sh000000;
    end else if (go || fin || kill) begin
      cnt_r <= 5'h00;
      acc_r <= 23'sh000000;
    end else if (more) begin
      cnt_r <= cnt_r + 5'h01;
      acc_r <= acc_nxt;
    end
  end

  // control registers; stop2 returns them to reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      ctrl2_r <= CTRL2_RST;
    end else if (stop2_mode) begin
      ctrl_r <= CTRL_RST;
      ctrl2_r <= CTRL2_RST;
    end else if (wr_ok) begin
      if (addr == A_CTRL) begin
        ctrl_r <= wdata;
      end
      if (addr == A_CTRL2) begin
        // start and cal are actions, not stored bits
        ctrl2_r <= wdata & 8'h1F;
      end
    end
  end

  // calibration busy bit and its start strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_r <= 1'b0;
      cal_start <= 1'b0;
    end else if (stop2_mode) begin
      cal_r <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      cal_start <= wr_ok && (addr == A_CTRL2) && wdata[C2_CAL];
      if (wr_ok && (addr == A_CTRL2) && wdata[C2_CAL]) begin
        cal_r <= 1'b1;
      end else if (cal_done) begin
        cal_r <= 1'b0;
      end
    end
  end

  // offset word: calibration loads it, software may override
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ofs_r <= OFS_RST;
    end else if (stop2_mode) begin
      ofs_r <= OFS_RST;
    end else if (cal_r && cal_done) begin
      ofs_r <= cal_offset;
    end else if (wr_ok && (addr == A_OFS_H)) begin
      ofs_r[15:8] <= wdata;
    end else if (wr_ok && (addr == A_OFS_L)) begin
      ofs_r[7:0] <= wdata;
    end
  end

  // result pair gets the saturated corrected value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res_r <= RES_RST;
    end else if (stop2_mode) begin
      res_r <= RES_RST;
    end else if (xfer) begin
      res_r <= sat_val;
    end
  end

  // stop3 hold: only the first plain result of a stop3 stay lands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s3_hold_r <= 1'b0;
    end else begin
      // leaving stop3 reopens the result pair for the next stay
      if (!stop3_mode || stop2_mode) begin
        s3_hold_r <= 1'b0;
      end else if (xfer && plain) begin
        s3_hold_r <= 1'b1;
      end
    end
  end

  // done flag: write one clears, a new completion wins the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (stop2_mode) begin
      done_r <= 1'b0;
    end else if ((fin && pass) || (cal_r && cal_done)) begin
      done_r <= 1'b1;
    end else if (wr_ok && (addr == A_STAT) && wdata[S_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // interrupt request doubles as the wake-up from wait and stop3
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= done_r && ie && !stop2_mode;
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      A_CTRL: rd_mux = ctrl_r;
      A_CTRL2: rd_mux = ctrl2_r;
      A_STAT: rd_mux = {5'h00, cal_r, (state_r == ST_CONV), done_r};
      A_RES_H: rd_mux = res_r[15:8];
      A_RES_L: rd_mux = res_r[7:0];
      A_OFS_H: rd_mux = ofs_r[15:8];
      A_OFS_L: rd_mux = ofs_r[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  // limitation: the core is trusted to send one sample per start;
  // a stray sample while idle is dropped, since every sample path checks
  // the sequencer state before it touches the result or the flag

endmodule

`default_nettype wire

// *** sim/aoc_ctrl_properties.sv ***
// Purpose: port-level checks for aoc_ctrl
// Assumes: one clock, reset active high, one-cycle strobe latency
// Notes: converter state is inferred from port history only
`timescale 1ns/10ps
`default_nettype none
module aoc_ctrl_properties
  import aoc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic hw_trig,
  input wire logic wait_mode,
  input wire logic stop3_mode,
  input wire logic stop2_mode,
  input wire logic samp_valid,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic cal_start,
  input wire logic irq
);
  // no stop, no write: nothing may kill a conversion here
  wire quiet = wait_mode && !stop3_mode && !stop2_mode && !wr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_start_has_cause: assert property (
    conv_start |-> $past(wr) || $past(hw_trig) || $past(samp_valid))
    else $error("start pulse without a cause");
  a_stop2_no_start: assert property ($past(stop2_mode) |-> !conv_start)
    else $error("start while in deepest stop");
  a_wait_sw_refused: assert property (
    $past(wait_mode && wr && !hw_trig && !samp_valid) |-> !conv_start)
    else $error("software start taken in wait");
  a_stop3_sw_refused: assert property (
    $past(stop3_mode && wr && !hw_trig && !samp_valid) |-> !conv_start)
    else $error("software start taken in stop3");
  a_wait_no_abort: assert property ($past(quiet) && $past(quiet, 2) |-> !conv_abort)
    else $error("conversion aborted in wait");
  a_stop2_irq_low: assert property ($past(stop2_mode, 2) |-> !irq)
    else $error("interrupt survives deepest stop");
  a_stop2_reads_zero: assert property (
    $past(stop2_mode, 2) && $past(rd) |-> rdata == 8'h00)
    else $error("register not cleared by deepest stop");
  a_abort_single: assert property (conv_abort |=> !conv_abort)
    else $error("abort pulse longer than one cycle");
  a_cal_start_cause: assert property (
    cal_start |-> $past(wr && addr == A_CTRL2 && wdata[C2_CAL]))
    else $error("calibration start without request");
  c_abort: cover property (conv_abort);
  c_irq: cover property (irq);
  c_cal: cover property (cal_start);
endmodule
bind aoc_ctrl aoc_ctrl_properties u_props (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hw_trig(hw_trig),
  .wait_mode(wait_mode), .stop3_mode(stop3_mode), .stop2_mode(stop2_mode),
  .samp_valid(samp_valid), .conv_start(conv_start), .conv_abort(conv_abort),
  .cal_start(cal_start), .irq(irq));
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for aoc_ctrl
// Assumes: read data stands the cycle after the strobe
// Notes: compare input driven per scenario, held beside each sample
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import aoc_pkg::*;
;
  logic mclk, rst, wr, rd, hw_trig, wait_mode, stop3_mode, stop2_mode, samp_valid;
  logic cal_done, conv_start, conv_abort, cal_start, irq, rd_d, d, ie, cmp_true;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] samp_data, cal_offset, o, s;
  logic [1:0] m;
  logic [7:0] q[$];
  int n_fail, check_count, cyc, n_start, n_abort, n_cal, seed, i, j, rv;

  aoc_ctrl dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hw_trig(hw_trig), .wait_mode(wait_mode), .stop3_mode(stop3_mode),
    .stop2_mode(stop2_mode), .samp_valid(samp_valid), .samp_data(samp_data),
    .cmp_true(cmp_true), .cal_done(cal_done), .cal_offset(cal_offset),
    .conv_start(conv_start), .conv_abort(conv_abort), .cal_start(cal_start), .irq(irq));

  always #50 mclk = ~mclk;

  task close_out;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pulses are counted, so a one-cycle pulse is never missed
  always @(posedge mclk) begin
    cyc++;
    if (conv_start === 1'b1) n_start++;
    if (conv_abort === 1'b1) n_abort++;
    if (cal_start === 1'b1) n_cal++;
    if (cyc > 5000) begin
      n_fail++;
      close_out;
    end
  end

  // read data is due one cycle after each read strobe
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) chk({8'h00, rdata}, {8'h00, q.pop_front()});
  end

  // idle edge after each strobe so no signal is set twice in one step
  task bus(input logic w, input logic [2:0] a, input logic [7:0] dt);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= dt;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task rdx(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  task wait_start(input int n0);
    for (int k = 0; k < 8 && n_start == n0; k++) @(posedge mclk);
    chk(16'(n_start - n0), 16'h0001);
  endtask

  function automatic int nb(input logic [1:0] md, input logic df);
    return (md == M_8 ? 8 : md == M_12 ? 12 : md == M_10 ? 10 : 16) + int'(df && md != M_16);
  endfunction

  // offset weight depends on mode; clamp to the mode's code range
  function automatic logic [15:0] expv(input logic [15:0] sv, input logic [15:0] ov,
                                       input logic [1:0] md, input logic df);
    int n, sh, off, r, lo, hi;
    n = nb(md, df);
    sh = (df ? 16 : 15) - n;
    off = sh < 0 ? 2 * int'($signed(ov)) : int'($signed(ov)) >>> sh;
    r = (df ? int'($signed(sv)) : int'(sv)) - off;
    lo = df ? -(1 << (n - 1)) : 0;
    hi = df ? (1 << (n - 1)) - 1 : (1 << n) - 1;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r[15:0];
  endfunction

  task automatic conv(input logic hw, input logic [15:0] sv, input logic [15:0] e,
                      input logic ien, input logic [3:0] c2);
    int n0;
    n0 = n_start;
    if (hw) begin
      hw_trig <= 1'b1;
      @(posedge mclk);
      hw_trig <= 1'b0;
    end else bus(1'b1, A_CTRL2, {2'b00, 1'b1, ien, c2});
    wait_start(n0);
    samp_valid <= 1'b1;
    samp_data <= sv;
    @(posedge mclk);
    samp_valid <= 1'b0;
    @(posedge mclk);
    rdx(A_RES_H, e[15:8]);
    rdx(A_RES_L, e[7:0]);
    rdx(A_STAT, 8'h01);
    chk({15'h0, irq}, {15'h0, ien});
    bus(1'b1, A_STAT, 8'h01);
  endtask

  initial begin
    seed = 51239;
    mclk = 1'b0;
    rst = 1'b1;
    {wr, rd, hw_trig, wait_mode, stop3_mode, stop2_mode, samp_valid, cal_done, cmp_true} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    samp_data = 16'h0000;
    cal_offset = 16'h0000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // random modes, offsets and samples; large offsets drive clamping
    for (i = 0; i < 40; i++) begin
      m = 2'($random(seed));
      d = 1'($random(seed));
      ie = 1'($random(seed));
      o = 16'($random(seed));
      rv = $random(seed);
      j = nb(m, d);
      rv = d ? (rv <<< (32 - j)) >>> (32 - j) : rv & ((1 << j) - 1);
      s = rv[15:0];
      bus(1'b1, A_CTRL, {4'h0, d, m, 1'b1});
      bus(1'b1, A_OFS_H, o[15:8]);
      bus(1'b1, A_OFS_L, o[7:0]);
      rdx(A_OFS_H, o[15:8]);
      conv(1'b0, s, expv(s, o, m, d), ie, 4'h0);
    end
    bus(1'b1, 3'h7, 8'hFF);
    rdx(3'h7, 8'h00);
    // calibration loads offset; writes meanwhile are dropped
    j = n_cal;
    bus(1'b1, A_CTRL2, 8'h50);
    bus(1'b1, A_OFS_L, 8'h55);
    cal_offset <= 16'hC3A6;
    cal_done <= 1'b1;
    @(posedge mclk);
    cal_done <= 1'b0;
    chk(16'(n_cal - j), 16'h0001);
    rdx(A_OFS_H, 8'hC3);
    rdx(A_OFS_L, 8'hA6);
    chk({15'h0, irq}, 16'h0001);
    bus(1'b1, A_OFS_L, 8'h11);
    rdx(A_OFS_L, 8'h11);
    // deepest stop clears everything
    stop2_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    stop2_mode <= 1'b0;
    rdx(A_OFS_L, 8'h00);
    rdx(A_CTRL, 8'h00);
    // wait: software start refused, hardware trigger taken
    wait_mode <= 1'b1;
    bus(1'b1, A_CTRL, 8'h01);
    j = n_start;
    bus(1'b1, A_CTRL2, 8'h20);
    repeat (3) @(posedge mclk);
    chk(16'(n_start - j), 16'h0000);
    bus(1'b1, A_CTRL, 8'h21);
    conv(1'b1, 16'h005A, 16'h005A, 1'b0, 4'h0);
    // stop3 on bus clock aborts, registers kept
    wait_mode <= 1'b0;
    bus(1'b1, A_CTRL, 8'h01);
    i = n_abort;
    j = n_start;
    bus(1'b1, A_CTRL2, 8'h20);
    wait_start(j);
    stop3_mode <= 1'b1;
    // a software start inside stop3 must be refused
    bus(1'b1, A_CTRL2, 8'h20);
    @(posedge mclk);
    stop3_mode <= 1'b0;
    chk(16'(n_abort - i), 16'h0001);
    chk(16'(n_start - j), 16'h0001);
    rdx(A_RES_L, 8'h5A);
    rdx(A_STAT, 8'h00);
    // averaging: four samples, one offset, one flag
    bus(1'b1, A_OFS_H, 8'h04);
    j = n_start;
    bus(1'b1, A_CTRL2, 8'h21);
    for (i = 0; i < 4; i++) begin
      samp_valid <= 1'b1;
      samp_data <= 16'(16 * (i + 1));
      @(posedge mclk);
      samp_valid <= 1'b0;
      @(posedge mclk);
    end
    chk(16'(n_start - j), 16'h0004);
    rdx(A_RES_L, 8'h20);
    rdx(A_STAT, 8'h01);
    bus(1'b1, A_STAT, 8'h01);
    // compare false in single mode: idle, no flag, result kept
    j = n_start;
    bus(1'b1, A_CTRL2, 8'h28);
    wait_start(j);
    samp_valid <= 1'b1;
    samp_data <= 16'h0077;
    @(posedge mclk);
    samp_valid <= 1'b0;
    @(posedge mclk);
    rdx(A_STAT, 8'h00);
    rdx(A_RES_L, 8'h20);
    chk(16'(n_start - j), 16'h0001);
    cmp_true <= 1'b1;
    conv(1'b0, 16'h0050, 16'h0048, 1'b0, 4'h8);
    // stop3 on the async clock: continuous runs on, first result held
    bus(1'b1, A_CTRL, 8'hD1);
    i = n_abort;
    j = n_start;
    bus(1'b1, A_CTRL2, 8'h30);
    wait_start(j);
    bus(1'b1, A_STAT, 8'h01);
    stop3_mode <= 1'b1;
    s = 16'h0030;
    repeat (2) begin
      samp_valid <= 1'b1;
      samp_data <= s;
      @(posedge mclk);
      samp_valid <= 1'b0;
      s = 16'h0060;
      @(posedge mclk);
    end
    stop3_mode <= 1'b0;
    chk(16'(n_abort - i), 16'h0000);
    rdx(A_RES_L, 8'h28);
    rdx(A_STAT, 8'h03);
    chk({15'h0, irq}, 16'h0001);
    bus(1'b1, A_CTRL, 8'h00);
    repeat (2) @(posedge mclk);
    close_out;
  end
endmodule
`default_nettype wire
